/* File: inc/wdt_map.vh */
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// ----------------------------------------------------------------------
// Register location on the core's special-function port
// ----------------------------------------------------------------------
`define WDT_SFR_ADDR 8'hC0

// ----------------------------------------------------------------------
// Field positions of the control and status register
// ----------------------------------------------------------------------
`define WDT_PRE_HI 7
`define WDT_PRE_LO 4
`define WDT_IRSP_BIT 3
`define WDT_STAT_BIT 2
`define WDT_EN_BIT 1
`define WDT_ARM_BIT 0

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define WDT_PRE_RST 4'h7
`define WDT_IRSP_RST 1'b0
`define WDT_STAT_RST 1'b0
`define WDT_EN_RST 1'b1
`define WDT_ARM_RST 1'b0

// ----------------------------------------------------------------------
// Prescaler codes and counter geometry
// ----------------------------------------------------------------------
`define WDT_PRE_MAX_TIMED 4'h7
`define WDT_PRE_AUTO_RST 4'h8
`define WDT_PRE_DL_RST 4'h9
`define WDT_CNT_W 16
`define WDT_BASE_SHIFT 5'h09

// ----------------------------------------------------------------------
// Timing of the reset pulse driven out on expiry
// ----------------------------------------------------------------------
`define WDT_CLK_PERIOD_NS 50
`define WDT_RST_PULSE_NS 1000
`define WDT_RST_PULSE_CYC ((`WDT_RST_PULSE_NS + `WDT_CLK_PERIOD_NS - 1) / `WDT_CLK_PERIOD_NS)

`endif

/* File: hw/wdt_sync.v */
// ----------------------------------------------------------------------
// Two-stage synchroniser for one level from outside the clock domain
// ----------------------------------------------------------------------
module wdt_sync (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Level in and out
    input wire async_in,
    output wire sync_out
);

    reg meta_reg;
    reg sync_reg;

    // Only the second stage is read, so a metastable first stage never
    // reaches any logic.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;

endmodule // wdt_sync

/* File: hw/wdt_counter.v */
`include "wdt_map.vh"

// ----------------------------------------------------------------------
// Watchdog counter with prescaler-selected terminal count
// ----------------------------------------------------------------------
module wdt_counter (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Control
    input wire tick,
    input wire clear,
    input wire run,
    input wire [3:0] pre,
    // Result
    output wire expire
);

    reg [`WDT_CNT_W-1:0] count_reg;
    reg expire_reg;

    // Terminal count is 2^(pre+9)-1, so expiry falls on tick 2^(pre+9).
    function [`WDT_CNT_W-1:0] wdt_term_mask;
        input [3:0] sel;
        reg [`WDT_CNT_W:0] one_hot;
        reg [`WDT_CNT_W:0] mask;
        begin
            one_hot = {{`WDT_CNT_W{1'b0}}, 1'b1} << ({1'b0, sel} + `WDT_BASE_SHIFT);
            mask = one_hot - {{`WDT_CNT_W{1'b0}}, 1'b1};
            wdt_term_mask = mask[`WDT_CNT_W-1:0];
        end
    endfunction

    wire at_term = (count_reg == wdt_term_mask(pre));

    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= {`WDT_CNT_W{1'b0}};
            expire_reg <= 1'b0;
        end else begin
            expire_reg <= 1'b0;
            if (clear) begin
                count_reg <= {`WDT_CNT_W{1'b0}};
            end else if (run && tick) begin
                if (at_term) begin
                    count_reg <= {`WDT_CNT_W{1'b0}};
                    expire_reg <= 1'b1;
                end else begin
                    count_reg <= count_reg + {{(`WDT_CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    assign expire = expire_reg;

endmodule // wdt_counter

/* File: hw/wdt_ctrl_top.v */
`include "wdt_map.vh"

module wdt_ctrl_top (
    // Clock and reset
    input wire sys_clk,
    input wire rst_n,
    // Crystal clock pin
    input wire crystal_input_clock,
    // Special-function register port of the core
    input wire [7:0] sfr_addr,
    input wire sfr_wr,
    input wire [7:0] sfr_wdata,
    input wire sfr_bit_wr,
    input wire [2:0] sfr_bit_sel,
    input wire sfr_bit_val,
    input wire sfr_rd,
    output wire [7:0] sfr_rdata,
    // Instruction boundary from the core
    input wire instr_end,
    // Protection bit from the flash byte, low means protected
    input wire wdt_protect_n,
    // Expiry actions
    output wire wdt_irq,
    output wire wdt_sys_reset,
    output wire wdt_download_reset,
    // Register fields for observation
    output wire expiry_response_select,
    output wire timeout_status_flag,
    output wire watchdog_enable_kick,
    output wire control_write_arm
);

    // ------------------------------------------------------------------
    // Arming states
    // ------------------------------------------------------------------
    localparam [1:0] ARM_IDLE = 2'h0;
    localparam [1:0] ARM_WAIT_END = 2'h1;
    localparam [1:0] ARM_READY = 2'h2;
    // The cycle count is an integer expression; only its low five bits are kept.
    localparam integer PULSE_CYC = `WDT_RST_PULSE_CYC;
    localparam [4:0] PULSE_LEN = PULSE_CYC[4:0];

    // ------------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------------
    reg rst_meta_reg;
    reg rst_sync_reg;
    wire rst_core_n = rst_sync_reg;

    // The reset asserts at once and releases two edges later, so the
    // whole block leaves reset on one clean edge.
    always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Crystal clock edge detection
    // ------------------------------------------------------------------
    wire xtal_sync;
    reg xtal_prev_reg;
    wire xtal_tick = xtal_sync & ~xtal_prev_reg;

    wdt_sync u_xtal_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_core_n),
        .async_in(crystal_input_clock),
        .sync_out(xtal_sync)
    );

    always @(posedge sys_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            xtal_prev_reg <= 1'b0;
        end else begin
            xtal_prev_reg <= xtal_sync;
        end
    end

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    reg [3:0] pre_reg;
    reg irsp_reg;
    reg stat_reg;
    reg en_reg;
    reg [1:0] arm_state_reg;
    reg [1:0] arm_state_next;
    reg [7:0] rdata_reg;
    reg irq_reg;
    reg sys_rst_reg;
    reg dl_rst_reg;
    reg [4:0] pulse_cnt_reg;
    reg arm_out_reg;

    // Bit writes read-modify-write the current contents.
    function [7:0] wdt_merge;
        input [7:0] cur;
        input [2:0] sel;
        input val;
        reg [7:0] tmp;
        begin
            tmp = cur;
            tmp[sel] = val;
            wdt_merge = tmp;
        end
    endfunction

    wire protected_w = ~wdt_protect_n;
    wire armed = (arm_state_reg != ARM_IDLE);
    wire [7:0] cur_val = {pre_reg, irsp_reg, stat_reg, en_reg, armed};
    wire reg_hit = (sfr_addr == `WDT_SFR_ADDR);
    wire byte_wr = sfr_wr & reg_hit;
    wire bit_wr = sfr_bit_wr & reg_hit;
    wire any_wr = byte_wr | bit_wr;
    wire [7:0] wr_val = byte_wr ? sfr_wdata : wdt_merge(cur_val, sfr_bit_sel, sfr_bit_val);
    wire wr_accept = any_wr & (arm_state_reg == ARM_READY);
    wire wr_arming = any_wr & ~wr_accept & wr_val[`WDT_ARM_BIT];
    wire kick = wr_accept & wr_val[`WDT_EN_BIT];

    // ------------------------------------------------------------------
    // Write arming sequence
    // ------------------------------------------------------------------
    always @* begin
        arm_state_next = arm_state_reg;
        if (wr_accept) begin
            arm_state_next = ARM_IDLE;
        end else if (wr_arming) begin
            arm_state_next = instr_end ? ARM_READY : ARM_WAIT_END;
        end else begin
            case (arm_state_reg)
                ARM_WAIT_END: begin
                    if (instr_end) begin
                        arm_state_next = ARM_READY;
                    end
                end
                ARM_READY: begin
                    if (instr_end) begin
                        arm_state_next = ARM_IDLE;
                    end
                end
                default: begin
                    arm_state_next = ARM_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Counter and expiry detection
    // ------------------------------------------------------------------
    wire timed_code = (pre_reg <= `WDT_PRE_MAX_TIMED);
    wire pulse_busy = (pulse_cnt_reg != 5'h00);
    wire timed_expire;
    // Codes 10 to 15 are never expected; they simply halt the counter.
    wire run = en_reg & timed_code & ~pulse_busy;
    wire auto_fire = en_reg & ~pulse_busy & (pre_reg == `WDT_PRE_AUTO_RST);
    wire dl_fire = en_reg & ~pulse_busy & (pre_reg == `WDT_PRE_DL_RST);
    wire timed_rst = timed_expire & ~irsp_reg;
    wire timed_irq = timed_expire & irsp_reg;
    wire rst_fire = timed_rst | auto_fire | dl_fire;
    wire any_timeout = timed_expire | auto_fire | dl_fire;

    wdt_counter u_counter (
        .sys_clk(sys_clk),
        .rst_n(rst_core_n),
        .tick(xtal_tick),
        .clear(kick | rst_fire),
        .run(run),
        .pre(pre_reg),
        .expire(timed_expire)
    );

    // ------------------------------------------------------------------
    // Control and status fields
    // ------------------------------------------------------------------
    // A watchdog reset restores the control fields to their defaults,
    // but the status bit is left alone so software can see the cause.
    always @(posedge sys_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            pre_reg <= `WDT_PRE_RST;
            irsp_reg <= `WDT_IRSP_RST;
            en_reg <= `WDT_EN_RST;
            arm_state_reg <= ARM_IDLE;
            arm_out_reg <= 1'b0;
        end else begin
            if (rst_fire) begin
                pre_reg <= `WDT_PRE_RST;
                irsp_reg <= `WDT_IRSP_RST;
                en_reg <= `WDT_EN_RST;
                arm_state_reg <= ARM_IDLE;
                arm_out_reg <= 1'b0;
            end else begin
                arm_state_reg <= arm_state_next;
                arm_out_reg <= (arm_state_next != ARM_IDLE);
                if (wr_accept) begin
                    pre_reg <= wr_val[`WDT_PRE_HI:`WDT_PRE_LO];
                end
                if (protected_w) begin
                    irsp_reg <= 1'b0;
                    en_reg <= 1'b1;
                end else if (wr_accept) begin
                    irsp_reg <= wr_val[`WDT_IRSP_BIT];
                    en_reg <= wr_val[`WDT_EN_BIT];
                end
            end
        end
    end

    // Only the pin reset reaches this flop; a set beats a clear.
    always @(posedge sys_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            stat_reg <= `WDT_STAT_RST;
        end else if (any_timeout) begin
            stat_reg <= 1'b1;
        end else if (wr_accept && !wr_val[`WDT_STAT_BIT]) begin
            stat_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Expiry actions
    // ------------------------------------------------------------------
    // The interrupt line is a registered copy of the timed expiry while the
    // response bit selects an interrupt, so each expiry gives a one-cycle
    // pulse and no system reset.
    always @(posedge sys_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= timed_irq;
        end
    end

    always @(posedge sys_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            pulse_cnt_reg <= 5'h00;
            sys_rst_reg <= 1'b0;
            dl_rst_reg <= 1'b0;
        end else if (rst_fire) begin
            pulse_cnt_reg <= PULSE_LEN;
            sys_rst_reg <= 1'b1;
            dl_rst_reg <= dl_fire;
        end else if (pulse_busy) begin
            pulse_cnt_reg <= pulse_cnt_reg - 5'h01;
            if (pulse_cnt_reg == 5'h01) begin
                sys_rst_reg <= 1'b0;
                dl_rst_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always @(posedge sys_clk or negedge rst_core_n) begin
        if (!rst_core_n) begin
            rdata_reg <= 8'h00;
        end else if (sfr_rd && reg_hit) begin
            rdata_reg <= cur_val;
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign sfr_rdata = rdata_reg;
    assign wdt_irq = irq_reg;
    assign wdt_sys_reset = sys_rst_reg;
    assign wdt_download_reset = dl_rst_reg;
    assign expiry_response_select = irsp_reg;
    assign timeout_status_flag = stat_reg;
    assign watchdog_enable_kick = en_reg;
    // The arm flag keeps a flop of its own so that the port does not carry
    // the decode of the arming state.
    assign control_write_arm = arm_out_reg;

endmodule // wdt_ctrl_top

/* File: tb/wdt_ctrl_top_properties.sv */
// ----------------------------------------------------------------------
// Port-level properties of the watchdog block
// ----------------------------------------------------------------------
module wdt_ctrl_top_chk (
    // Clock and reset
    input logic sys_clk,
    input logic rst_n,
    // Register port
    input logic [7:0] sfr_addr,
    input logic sfr_wr,
    input logic sfr_bit_wr,
    input logic wdt_protect_n,
    // Expiry actions and fields
    input logic wdt_irq,
    input logic wdt_sys_reset,
    input logic wdt_download_reset,
    input logic expiry_response_select,
    input logic timeout_status_flag,
    input logic watchdog_enable_kick,
    input logic control_write_arm
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_irq_pulse: assert property (wdt_irq |=> !wdt_irq)
        else $error("interrupt pulse longer than one cycle");
    a_irq_mode: assert property (wdt_irq |-> expiry_response_select && timeout_status_flag)
        else $error("interrupt without response bit or status");
    a_rst_status: assert property ($rose(wdt_sys_reset) |-> timeout_status_flag && !wdt_irq)
        else $error("reset without status or with interrupt");
    a_rst_width: assert property ($rose(wdt_sys_reset) |->
        wdt_sys_reset [*8] ##12 wdt_sys_reset ##1 !wdt_sys_reset)
        else $error("reset pulse width wrong");
    a_rst_defaults: assert property ($rose(wdt_sys_reset) |->
        !expiry_response_select && watchdog_enable_kick && !control_write_arm)
        else $error("fields not reverted on watchdog reset");
    a_dl_in_rst: assert property (wdt_download_reset |-> wdt_sys_reset)
        else $error("download reset outside system reset");
    a_stat_sticky: assert property (timeout_status_flag && !sfr_wr && !sfr_bit_wr
        |=> timeout_status_flag)
        else $error("status cleared without a write");
    a_stat_cause: assert property ($rose(timeout_status_flag) |-> wdt_irq || wdt_sys_reset)
        else $error("status set without expiry");
    a_prot_force: assert property (!wdt_protect_n
        |=> !expiry_response_select && watchdog_enable_kick)
        else $error("protection did not force fields");
    a_unarmed_drop: assert property (!control_write_arm && sfr_wr && sfr_addr == 8'hC0
        && wdt_protect_n && !wdt_sys_reset
        |=> $stable(expiry_response_select) && $stable(watchdog_enable_kick))
        else $error("unarmed write changed fields");

    c_irq: cover property (wdt_irq);
    c_dl: cover property ($rose(wdt_sys_reset) && wdt_download_reset);
    c_prot: cover property (!wdt_protect_n && sfr_wr);
endmodule // wdt_ctrl_top_chk

bind wdt_ctrl_top wdt_ctrl_top_chk i_wdt_ctrl_top_chk (.sys_clk, .rst_n, .sfr_addr, .sfr_wr,
    .sfr_bit_wr, .wdt_protect_n, .wdt_irq, .wdt_sys_reset, .wdt_download_reset,
    .expiry_response_select, .timeout_status_flag, .watchdog_enable_kick, .control_write_arm);

/* File: tb/test_wdt_ctrl_top.sv */
module test_wdt_ctrl_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk, rst_n, xtal, wr, bit_wr, bit_val, rd, ie, prot_n, rd_seen;
    logic [7:0] addr, wdata;
    logic [2:0] bit_sel;
    logic [3:0] code;
    wire [7:0] rdata;
    wire irq, srst, dlrst, bit3, stat, en, arm;
    integer miscompares = 0, checks = 0, n, i;
    logic [7:0] exq[$];

    wdt_ctrl_top i_wdt_ctrl_top (.sys_clk(sys_clk), .rst_n(rst_n), .crystal_input_clock(xtal),
        .sfr_addr(addr), .sfr_wr(wr), .sfr_wdata(wdata), .sfr_bit_wr(bit_wr),
        .sfr_bit_sel(bit_sel), .sfr_bit_val(bit_val), .sfr_rd(rd), .sfr_rdata(rdata),
        .instr_end(ie), .wdt_protect_n(prot_n), .wdt_irq(irq), .wdt_sys_reset(srst),
        .wdt_download_reset(dlrst), .expiry_response_select(bit3),
        .timeout_status_flag(stat), .watchdog_enable_kick(en), .control_write_arm(arm));

    // ----------------------------------------------------------------------
    // Clocks
    // ----------------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end
    // The crystal runs fast, eight cycles a period, so a short timeout stays short.
    initial begin
        xtal = 1'b0;
        forever #200 xtal = ~xtal;
    end

    // ----------------------------------------------------------------------
    // Checking and bus tasks
    // ----------------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report;
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic ins(input logic [7:0] a, input logic bw, input logic w, input logic [7:0] d,
                       input logic [2:0] s, input logic v);
        @(negedge sys_clk);
        addr = a;
        bit_wr = bw;
        wr = w;
        wdata = d;
        bit_sel = s;
        bit_val = v;
        ie = 1'b1;
        @(negedge sys_clk);
        bit_wr = 1'b0;
        wr = 1'b0;
        ie = 1'b0;
        addr = 8'hC0;
        @(negedge sys_clk);
    endtask

    task automatic wrb(input logic [7:0] d);
        ins(8'hC0, 1'b1, 1'b0, 8'h00, 3'h0, 1'b1);
        ins(8'hC0, 1'b0, 1'b1, d, 3'h0, 1'b0);
    endtask

    task automatic wbit(input logic [2:0] s, input logic v);
        ins(8'hC0, 1'b1, 1'b0, 8'h00, 3'h0, 1'b1);
        ins(8'hC0, 1'b1, 1'b0, 8'h00, s, v);
    endtask

    task automatic rd_reg(input logic [7:0] e);
        @(negedge sys_clk);
        rd = 1'b1;
        exq.push_back(e);
        @(negedge sys_clk);
        rd = 1'b0;
        @(negedge sys_clk);
    endtask

    task automatic wt(input integer lim, input logic must, output integer cnt);
        cnt = 0;
        while (cnt < lim && !(irq === 1'b1 || srst === 1'b1)) begin
            @(negedge sys_clk);
            cnt++;
        end
        if (must && cnt >= lim) begin
            miscompares++;
            final_report();
        end
    endtask

    always @(posedge sys_clk) rd_seen <= rd;
    always @(negedge sys_clk) begin
        if (rd_seen === 1'b1 && exq.size() > 0) begin
            chk("register read", rdata, exq.pop_front());
        end
    end

    // ----------------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        {wr, bit_wr, bit_val, rd, ie} = 5'h00;
        prot_n = 1'b1;
        addr = 8'hC0;
        wdata = 8'h00;
        bit_sel = 3'h0;
        void'($urandom(32'h77a06d13));
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        rd_reg(8'h72);
        for (i = 0; i < 4; i++) begin
            code = 4'($urandom % 8);
            wrb({code, 4'h2});
            rd_reg({code, 4'h2});
        end
        ins(8'hC0, 1'b0, 1'b1, 8'h00, 3'h0, 1'b0);
        rd_reg({code, 4'h2});
        ins(8'hC0, 1'b1, 1'b0, 8'h00, 3'h0, 1'b1);
        rd_reg({code, 4'h3});
        chk("arm bit", arm, 1'b1);
        ins(8'h55, 1'b0, 1'b1, 8'h00, 3'h0, 1'b0);
        ins(8'hC0, 1'b0, 1'b1, 8'h00, 3'h0, 1'b0);
        rd_reg({code, 4'h2});
        // A kick halfway through must push the expiry a full period out.
        wrb(8'h02);
        wt(2000, 1'b0, n);
        chk("early expiry", n == 2000, 1'b1);
        wbit(3'h1, 1'b1);
        wt(4200, 1'b1, n);
        chk("timeout length", n >= 4080 && n <= 4115, 1'b1);
        chk("reset out", {irq, srst, dlrst, stat}, 4'h5);
        repeat (25) @(negedge sys_clk);
        rd_reg(8'h76);
        wrb(8'h0A);
        rd_reg(8'h0A);
        wt(4200, 1'b1, n);
        chk("irq out", {irq, srst, stat}, 3'h5);
        rd_reg(8'h0E);
        wbit(3'h2, 1'b0);
        rd_reg(8'h0A);
        wrb(8'h08);
        wt(4500, 1'b0, n);
        chk("disabled", n == 4500, 1'b1);
        for (code = 4'h8; code < 4'hA; code++) begin
            wrb({code, 4'h2});
            wt(50, 1'b1, n);
            chk("download reset", dlrst, code[0]);
            repeat (25) @(negedge sys_clk);
            rd_reg(8'h76);
        end
        prot_n = 1'b0;
        wrb(8'h0C);
        rd_reg(8'h06);
        chk("fields", {bit3, stat, en, arm}, 4'h6);
        rst_n = 1'b0;
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        prot_n = 1'b1;
        repeat (3) @(negedge sys_clk);
        rd_reg(8'h72);
        chk("fields after pin reset", {bit3, stat, en, arm}, 4'h2);
        final_report();
    end
endmodule // test_wdt_ctrl_top
